/* File: hdl/apea_pkg.sv */
// Package for the apparent power and energy block: offsets, fields,
// reset values and timing counts.
// Assumes a single 25 MHz clock and a 4-bit word-addressed register port.
package apea_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ           = 25_000_000;
   localparam int ACC_HZ           = 1_024_000;
   localparam int SAMPLE_HZ        = 8_000;
   localparam int DIV_INC          = ACC_HZ / 1000;
   localparam int DIV_MOD          = CLK_HZ / 1000;
   localparam int TICKS_PER_SAMPLE = ACC_HZ / SAMPLE_HZ;
   localparam int DIV_W            = 15;
   localparam int SCNT_W           = 7;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int ADDR_W    = 4;
   localparam int DATA_W    = 32;
   localparam int PWR_W     = 24;
   localparam int GAIN_W    = 24;
   localparam int THR_W     = 8;
   localparam int THR_SHIFT = 27;
   localparam int ACC_W     = 36;
   localparam int CNT_W     = 32;
   localparam int SCL_W     = 25;
   localparam int NPHASE    = 3;

   // ------------------------------------------------------------
   // Power scaling
   // ------------------------------------------------------------
   localparam longint FULL_SCALE_POWER_CONSTANT = 27_059_678;
   localparam longint RMS_FULL_SCALE_CODE       = 3_766_572;
   localparam int     PWR_SHIFT = 4;
   localparam int     K_FRAC    = 38;
   localparam int     PWR_FRAC  = K_FRAC + PWR_SHIFT;
   localparam int     K_W       = 20;
   localparam int     PROD_W    = 2 * PWR_W + K_W;
   localparam logic [K_W-1:0] PWR_K = K_W'((FULL_SCALE_POWER_CONSTANT << K_FRAC)
                                     / (RMS_FULL_SCALE_CODE * RMS_FULL_SCALE_CODE));

   // ------------------------------------------------------------
   // Register offsets (word index)
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_POWER_A     = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_POWER_B     = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_POWER_C     = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_NOMINAL_V   = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_THRESHOLD   = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_ENERGY_A    = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_ENERGY_B    = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_ENERGY_C    = 4'h7;
   localparam logic [ADDR_W-1:0] OFS_GAIN_A      = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_GAIN_B      = 4'h9;
   localparam logic [ADDR_W-1:0] OFS_GAIN_C      = 4'ha;
   localparam logic [ADDR_W-1:0] OFS_COMP_CFG    = 4'hb;
   localparam logic [ADDR_W-1:0] OFS_LINE_CFG    = 4'hc;
   localparam logic [ADDR_W-1:0] OFS_STATUS      = 4'hd;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK    = 4'he;

   // ------------------------------------------------------------
   // Fields and reset values
   // ------------------------------------------------------------
   localparam int NOMEN_A_BIT     = 11;
   localparam int CLR_ON_READ_BIT = 6;
   localparam int HALF_FULL_BIT   = 4;
   localparam int ENERGY_HALF_BIT = 30;
   localparam logic [THR_W-1:0] THR_RST = 8'h03;

endpackage : apea_pkg

/* File: hdl/apea_phase.sv */
// One phase of the two-stage energy integrator: threshold accumulator
// feeding a 32-bit pulse counter.
// Assumes the scaled power is non-negative and steady between ticks.
`timescale 1ns/100ps
module apea_phase
   import apea_pkg::*;
(
   input  wire logic                        ref_clk,
   input  wire logic                        rstn,
   input  wire logic                        acc_tick,
   input  wire logic [apea_pkg::SCL_W-1:0]  scaled_power,
   input  wire logic [apea_pkg::THR_W-1:0]  threshold,
   input  wire logic                        clear_count,
   output      logic [apea_pkg::CNT_W-1:0]  energy_count,
   output      logic                        energy_pulse,
   output      logic                        half_full_evt
);
   import apea_pkg::*;

   logic [ACC_W-1:0] acc_ff;
   logic [ACC_W-1:0] nxt_acc;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic [ACC_W-1:0] sum;
   logic [ACC_W-1:0] thr_full;
   logic             pulse;

   // ------------------------------------------------------------
   // Integrator
   // ------------------------------------------------------------
   always_comb begin
      thr_full = {1'b0, threshold, THR_SHIFT'(0)};
      sum      = acc_ff + {(ACC_W-SCL_W)'(0), scaled_power};
      // Zero threshold would pulse forever; hold the integrator instead
      pulse    = acc_tick && (threshold != '0) && (sum >= thr_full);
      nxt_acc  = acc_ff;
      if (acc_tick && (threshold != '0)) begin
         nxt_acc = pulse ? sum - thr_full : sum;
      end
      if (pulse) begin
         nxt_acc = sum - thr_full;
      end
      // A pulse in the clearing cycle is kept
      nxt_cnt = clear_count ? {(CNT_W-1)'(0), pulse}
                            : cnt_ff + {(CNT_W-1)'(0), pulse};
      half_full_evt = pulse && !clear_count
                   && (nxt_cnt[ENERGY_HALF_BIT] != cnt_ff[ENERGY_HALF_BIT]);
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         acc_ff <= '0;
         cnt_ff <= '0;
      end else begin
         acc_ff <= nxt_acc;
         cnt_ff <= nxt_cnt;
      end
   end

   assign energy_count = cnt_ff;
   assign energy_pulse = pulse;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_acc_remainder: assert property (@(posedge ref_clk) disable iff (!rstn)
      pulse |=> acc_ff == $past(acc_ff) + {11'h0, $past(scaled_power)} - $past(thr_full))
      else $error("remainder after threshold wrong");
   a_count_step: assert property (@(posedge ref_clk) disable iff (!rstn)
      (pulse && !clear_count) |=> cnt_ff == $past(cnt_ff) + 32'h1)
      else $error("energy count did not step");

endmodule : apea_phase

/* File: hdl/apea_top.sv */
// Apparent power and energy block for three phases.
// Assumes rms inputs come from logic on ref_clk, full scale 3,766,572.
//
// Function
// - Power equals Vrms times Irms, FULL_SCALE_POWER_CONSTANT, /16
// - Per-phase 24-bit power on waveform outputs
// - Per-phase signed gain scales average power
// - No offset correction of apparent power
// - Nominal enable replaces measured voltage rms
// - Enables reset to zero: measured voltage
// - Nominal voltage read with zero top byte
// - 8 kHz power added at 1.024 MHz
// - Threshold reached: pulse, subtract, keep remainder
// - Pulses counted into 32-bit energy register
// - Threshold is 8 bits shifted by 27
// - Threshold resets to 3, max 255
// - Energy register wraps to full negative
// - Bit 30 change sets half-full status
// - Masked half-full drives interrupt pin low
// - Write one clears status, pin high
// - Clear-on-read enable zeroes energy after read
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/100ps
module apea_top
   import apea_pkg::*;
(
   input  wire logic                         ref_clk,
   input  wire logic                         rstn,
   input  wire logic [apea_pkg::PWR_W-1:0]   phase_a_voltage_rms,
   input  wire logic [apea_pkg::PWR_W-1:0]   phase_b_voltage_rms,
   input  wire logic [apea_pkg::PWR_W-1:0]   phase_c_voltage_rms,
   input  wire logic [apea_pkg::PWR_W-1:0]   phase_a_current_rms,
   input  wire logic [apea_pkg::PWR_W-1:0]   phase_b_current_rms,
   input  wire logic [apea_pkg::PWR_W-1:0]   phase_c_current_rms,
   input  wire logic [apea_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [apea_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output      logic [apea_pkg::DATA_W-1:0]  reg_rdata,
   output      logic                         primary_interrupt_pin_n,
   output      logic [apea_pkg::PWR_W-1:0]   phase_a_apparent_power,
   output      logic [apea_pkg::PWR_W-1:0]   phase_b_apparent_power,
   output      logic [apea_pkg::PWR_W-1:0]   phase_c_apparent_power,
   output      logic                         apparent_power_strobe
);
   import apea_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [DIV_W-1:0]   div_ff;
   logic [DIV_W-1:0]   nxt_div;
   logic [SCNT_W-1:0]  scnt_ff;
   logic [SCNT_W-1:0]  nxt_scnt;
   logic               acc_tick_ff;
   logic               nxt_acc_tick;
   logic               sample_tick_ff;
   logic               nxt_sample_tick;
   logic               strobe_ff;

   logic [PWR_W-1:0]   nominal_voltage_ff;
   logic [PWR_W-1:0]   nxt_nominal_voltage;
   logic [THR_W-1:0]   threshold_ff;
   logic [THR_W-1:0]   nxt_threshold;
   logic [GAIN_W-1:0]  gain_ff      [NPHASE];
   logic [GAIN_W-1:0]  nxt_gain     [NPHASE];
   logic [NPHASE-1:0]  nom_en_ff;
   logic [NPHASE-1:0]  nxt_nom_en;
   logic               clear_on_read_ff;
   logic               nxt_clear_on_read;
   logic               half_full_ff;
   logic               nxt_half_full;
   logic               half_mask_ff;
   logic               nxt_half_mask;
   logic               irq_n_ff;
   logic               nxt_irq_n;
   logic [DATA_W-1:0]  rdata_ff;
   logic [DATA_W-1:0]  nxt_rdata;

   logic [PWR_W-1:0]   vrms         [NPHASE];
   logic [PWR_W-1:0]   irms         [NPHASE];
   logic [PWR_W-1:0]   power_ff     [NPHASE];
   logic [PWR_W-1:0]   nxt_power    [NPHASE];
   logic [SCL_W-1:0]   scaled_ff    [NPHASE];
   logic [SCL_W-1:0]   nxt_scaled   [NPHASE];
   logic [CNT_W-1:0]   energy       [NPHASE];
   logic [NPHASE-1:0]  energy_pulse;
   logic [NPHASE-1:0]  half_evt;
   logic [NPHASE-1:0]  clear_cnt;

   assign vrms[0] = phase_a_voltage_rms;
   assign vrms[1] = phase_b_voltage_rms;
   assign vrms[2] = phase_c_voltage_rms;
   assign irms[0] = phase_a_current_rms;
   assign irms[1] = phase_b_current_rms;
   assign irms[2] = phase_c_current_rms;

   // ------------------------------------------------------------
   // Rate dividers
   // ------------------------------------------------------------
   // Fractional step gives 1.024 MHz on average from 25 MHz; jitter of
   // one clock is harmless to an integrator.
   always_comb begin
      nxt_div         = div_ff + DIV_W'(DIV_INC);
      nxt_acc_tick    = 1'b0;
      nxt_scnt        = scnt_ff;
      nxt_sample_tick = 1'b0;
      if (nxt_div >= DIV_W'(DIV_MOD)) begin
         nxt_div      = nxt_div - DIV_W'(DIV_MOD);
         nxt_acc_tick = 1'b1;
      end
      if (acc_tick_ff) begin
         nxt_scnt = scnt_ff + SCNT_W'(1);
         if (scnt_ff == SCNT_W'(TICKS_PER_SAMPLE - 1)) begin
            nxt_sample_tick = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         div_ff         <= '0;
         scnt_ff        <= '0;
         acc_tick_ff    <= 1'b0;
         sample_tick_ff <= 1'b0;
         strobe_ff      <= 1'b0;
      end else begin
         div_ff         <= nxt_div;
         scnt_ff        <= nxt_scnt;
         acc_tick_ff    <= nxt_acc_tick;
         sample_tick_ff <= nxt_sample_tick;
         strobe_ff      <= sample_tick_ff;
      end
   end

   // ------------------------------------------------------------
   // Power per phase
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NPHASE; g++) begin : g_phase
         logic [PWR_W-1:0]   v_sel;
         logic [PROD_W-1:0]  prod;
         logic signed [48:0] gain_prod;
         logic signed [25:0] scaled_s;

         always_comb begin
            // Negative nominal voltage has no meaning here; clamp to zero
            v_sel = nom_en_ff[g] ? (nominal_voltage_ff[PWR_W-1] ? '0 : nominal_voltage_ff)
                                 : vrms[g];
            // Offsets live in the rms inputs only
            prod  = PROD_W'(v_sel) * PROD_W'(irms[g]) * PROD_W'(PWR_K);
            nxt_power[g] = power_ff[g];
            if (sample_tick_ff) begin
               nxt_power[g] = (|prod[PROD_W-1:PWR_FRAC+PWR_W-1]) ? 24'h7fffff
                                                                 : {1'b0, prod[PWR_FRAC +: PWR_W-1]};
            end
            gain_prod = $signed({25'h0, power_ff[g]}) * $signed({{25{gain_ff[g][GAIN_W-1]}}, gain_ff[g]});
            scaled_s  = $signed({2'b00, power_ff[g]}) + gain_prod[48:23];
            nxt_scaled[g] = scaled_s[25] ? '0 : scaled_s[SCL_W-1:0];
         end

         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               power_ff[g]  <= '0;
               scaled_ff[g] <= '0;
            end else begin
               power_ff[g]  <= nxt_power[g];
               scaled_ff[g] <= nxt_scaled[g];
            end
         end

         assign clear_cnt[g] = reg_rd && clear_on_read_ff
                            && (reg_addr == OFS_ENERGY_A + ADDR_W'(g));

         apea_phase u_phase (
            .ref_clk       (ref_clk),
            .rstn          (rstn),
            .acc_tick      (acc_tick_ff),
            .scaled_power  (scaled_ff[g]),
            .threshold     (threshold_ff),
            .clear_count   (clear_cnt[g]),
            .energy_count  (energy[g]),
            .energy_pulse  (energy_pulse[g]),
            .half_full_evt (half_evt[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   always_comb begin
      nxt_nominal_voltage = nominal_voltage_ff;
      nxt_threshold       = threshold_ff;
      nxt_gain            = gain_ff;
      nxt_nom_en          = nom_en_ff;
      nxt_clear_on_read   = clear_on_read_ff;
      nxt_half_mask       = half_mask_ff;
      nxt_half_full       = half_full_ff;
      nxt_rdata           = '0;
      if (reg_wr) begin
         unique case (reg_addr)
            OFS_NOMINAL_V: nxt_nominal_voltage = reg_wdata[PWR_W-1:0];
            OFS_THRESHOLD: nxt_threshold       = reg_wdata[THR_W-1:0];
            OFS_GAIN_A:    nxt_gain[0]         = reg_wdata[GAIN_W-1:0];
            OFS_GAIN_B:    nxt_gain[1]         = reg_wdata[GAIN_W-1:0];
            OFS_GAIN_C:    nxt_gain[2]         = reg_wdata[GAIN_W-1:0];
            OFS_COMP_CFG:  nxt_nom_en          = reg_wdata[NOMEN_A_BIT +: NPHASE];
            OFS_LINE_CFG:  nxt_clear_on_read   = reg_wdata[CLR_ON_READ_BIT];
            OFS_STATUS: begin
               if (reg_wdata[HALF_FULL_BIT]) begin
                  nxt_half_full = 1'b0;
               end
            end
            OFS_IRQ_MASK:  nxt_half_mask       = reg_wdata[HALF_FULL_BIT];
            default: ;
         endcase
      end
      // Set wins over a same-cycle clear
      if (|half_evt) begin
         nxt_half_full = 1'b1;
      end
      nxt_irq_n = !(nxt_half_full && nxt_half_mask);
      if (reg_rd) begin
         unique case (reg_addr)
            OFS_POWER_A:   nxt_rdata = {{8{power_ff[0][PWR_W-1]}}, power_ff[0]};
            OFS_POWER_B:   nxt_rdata = {{8{power_ff[1][PWR_W-1]}}, power_ff[1]};
            OFS_POWER_C:   nxt_rdata = {{8{power_ff[2][PWR_W-1]}}, power_ff[2]};
            OFS_NOMINAL_V: nxt_rdata = {8'h00, nominal_voltage_ff};
            OFS_THRESHOLD: nxt_rdata = {24'h0, threshold_ff};
            OFS_ENERGY_A:  nxt_rdata = energy[0];
            OFS_ENERGY_B:  nxt_rdata = energy[1];
            OFS_ENERGY_C:  nxt_rdata = energy[2];
            OFS_GAIN_A:    nxt_rdata = {{8{gain_ff[0][GAIN_W-1]}}, gain_ff[0]};
            OFS_GAIN_B:    nxt_rdata = {{8{gain_ff[1][GAIN_W-1]}}, gain_ff[1]};
            OFS_GAIN_C:    nxt_rdata = {{8{gain_ff[2][GAIN_W-1]}}, gain_ff[2]};
            OFS_COMP_CFG:  nxt_rdata = DATA_W'(nom_en_ff) << NOMEN_A_BIT;
            OFS_LINE_CFG:  nxt_rdata = DATA_W'(clear_on_read_ff) << CLR_ON_READ_BIT;
            OFS_STATUS:    nxt_rdata = DATA_W'(half_full_ff) << HALF_FULL_BIT;
            OFS_IRQ_MASK:  nxt_rdata = DATA_W'(half_mask_ff) << HALF_FULL_BIT;
            default:       nxt_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         nominal_voltage_ff <= '0;
         threshold_ff       <= THR_RST;
         gain_ff            <= '{default: '0};
         nom_en_ff          <= '0;
         clear_on_read_ff   <= 1'b0;
         half_mask_ff       <= 1'b0;
         half_full_ff       <= 1'b0;
         irq_n_ff           <= 1'b1;
         rdata_ff           <= '0;
      end else begin
         nominal_voltage_ff <= nxt_nominal_voltage;
         threshold_ff       <= nxt_threshold;
         gain_ff            <= nxt_gain;
         nom_en_ff          <= nxt_nom_en;
         clear_on_read_ff   <= nxt_clear_on_read;
         half_mask_ff       <= nxt_half_mask;
         half_full_ff       <= nxt_half_full;
         irq_n_ff           <= nxt_irq_n;
         rdata_ff           <= nxt_rdata;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign reg_rdata               = rdata_ff;
   assign primary_interrupt_pin_n = irq_n_ff;
   assign phase_a_apparent_power  = power_ff[0];
   assign phase_b_apparent_power  = power_ff[1];
   assign phase_c_apparent_power  = power_ff[2];
   assign apparent_power_strobe   = strobe_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   a_nominal_pad: assert property (
      (reg_rd && reg_addr == OFS_NOMINAL_V) |=> reg_rdata == {8'h00, $past(nominal_voltage_ff)})
      else $error("nominal voltage read not zero padded");
   a_threshold_write: assert property (
      (reg_wr && reg_addr == OFS_THRESHOLD) |=> threshold_ff == $past(reg_wdata[THR_W-1:0]))
      else $error("threshold write lost");
   a_half_set: assert property (
      (|half_evt) |=> half_full_ff ##1 (half_full_ff || $past(reg_wr && reg_addr == OFS_STATUS)))
      else $error("half-full not set on event");
   a_irq_low: assert property (
      (|half_evt && half_mask_ff && !(reg_wr && reg_addr == OFS_IRQ_MASK)) |=> !primary_interrupt_pin_n)
      else $error("interrupt pin not low on masked event");
   a_status_clear: assert property (
      (reg_wr && reg_addr == OFS_STATUS && reg_wdata[HALF_FULL_BIT] && !(|half_evt))
      |=> !half_full_ff && primary_interrupt_pin_n)
      else $error("status write one did not clear");
   a_clear_read: assert property (
      (reg_rd && reg_addr == OFS_ENERGY_A && clear_on_read_ff && !energy_pulse[0])
      |=> energy[0] == 32'h0 && reg_rdata == $past(energy[0]))
      else $error("energy not cleared after read");
   a_tick_spacing: assert property (
      acc_tick_ff |=> !acc_tick_ff [*8])
      else $error("accumulate tick too frequent");
   a_sample_align: assert property (
      sample_tick_ff |-> $past(acc_tick_ff) && $past(scnt_ff) == 7'h7f)
      else $error("sample tick not on 128th accumulate tick");
   a_nominal_off: assert property (
      (sample_tick_ff && !nom_en_ff[0] && phase_a_voltage_rms == 24'h0) |=> phase_a_apparent_power == 24'h0)
      else $error("measured voltage not used");

   c_half_event:  cover property (|half_evt);
   c_clear_read:  cover property (|clear_cnt);
   c_irq_low:     cover property ($fell(primary_interrupt_pin_n));
   c_nominal_use: cover property (sample_tick_ff && |nom_en_ff);

endmodule : apea_top

/* File: verification/tb_apea_top.sv */
// Self-checking bench for the apparent power and energy block.
// Assumes the word map and power scaling held in apea_pkg.
`timescale 1ns/100ps
module tb_apea_top;
   import apea_pkg::*;
   localparam longint FS = RMS_FULL_SCALE_CODE;
   logic              ref_clk, rstn, reg_wr, reg_rd, irq_n, stb;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, rv;
   logic [PWR_W-1:0]  va, vb, vc, ia, ib, ic, pa, pb, pc;
   int                mismatches, comparisons, cyc;
   longint            e;
   apea_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .phase_a_voltage_rms(va), .phase_b_voltage_rms(vb),
      .phase_c_voltage_rms(vc), .phase_a_current_rms(ia), .phase_b_current_rms(ib),
      .phase_c_current_rms(ic), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .primary_interrupt_pin_n(irq_n),
      .phase_a_apparent_power(pa), .phase_b_apparent_power(pb), .phase_c_apparent_power(pc),
      .apparent_power_strobe(stb));
   // ------------------------------------------------------------
   // Clock, timeout and helpers
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // Full run needs about 53k cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 90000) begin
         mismatches++;
         summarize();
      end
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   task automatic chk(string n, logic [DATA_W-1:0] x, logic [DATA_W-1:0] g);
      comparisons++;
      if (g !== x) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   function automatic logic [PWR_W-1:0] pw(longint v, longint i);
      pw = PWR_W'((v * i * longint'(PWR_K)) >> PWR_FRAC);
   endfunction : pw
   task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(logic [ADDR_W-1:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask : rd
   // Strobe is looked at 1 ns after the edge, where it has settled
   task automatic ws();
      int k;
      for (k = 0; k < 4000 && stb !== 1'b1; k++) begin
         @(posedge ref_clk);
         #1;
      end
      chk("strobe_seen", 32'h1, 32'(stb === 1'b1));
      @(posedge ref_clk);
      #1 chk("strobe_width", 32'h0, 32'(stb));
   endtask : ws
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {va, vb, vc, ia, ib, ic} = '0;
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      rd(OFS_THRESHOLD); chk("threshold", 32'h3, rv);
      rd(OFS_COMP_CFG);  chk("comp_cfg", 32'h0, rv);
      rd(OFS_STATUS);    chk("status", 32'h0, rv);
      rd(4'hf);          chk("unmapped", 32'h0, rv);
      wr(OFS_POWER_A, 32'h5);
      rd(OFS_POWER_A);   chk("power_a_ro", 32'h0, rv);
      wr(OFS_NOMINAL_V, 32'hff1cbc96);
      rd(OFS_NOMINAL_V); chk("nominal", 32'h001cbc96, rv);
      wr(OFS_THRESHOLD, 32'hff);
      rd(OFS_THRESHOLD); chk("threshold_max", 32'hff, rv);
      wr(OFS_THRESHOLD, 32'h3);
      wr(OFS_COMP_CFG, 32'h1 << (NOMEN_A_BIT + 1));
      wr(OFS_IRQ_MASK, 32'h1 << HALF_FULL_BIT);
      rd(OFS_IRQ_MASK);  chk("irq_mask", 32'h10, rv);
      @(posedge ref_clk);
      {va, ia, ib, ic} <= {4{PWR_W'(FS)}};
      vc <= PWR_W'(FS / 4);
      ws();
      ws();
      chk("power_a", 32'(pw(FS, FS)), 32'(pa));
      chk("power_b", 32'(pw(32'h1cbc96, FS)), 32'(pb));
      chk("power_c", 32'(pw(FS / 4, FS)), 32'(pc));
      wr(OFS_LINE_CFG, 32'h1 << CLR_ON_READ_BIT);
      rd(OFS_ENERGY_A);
      repeat (30000) @(posedge ref_clk);
      rd(OFS_ENERGY_A);
      e = (longint'(30000) * 1024 / 25000) * longint'(pw(FS, FS)) / (longint'(3) << THR_SHIFT);
      comparisons++;
      if (longint'(rv) < e - 1 || longint'(rv) > e + 1) begin
         mismatches++;
         $display("[ERR] energy_a expected %0d seen %0d", e, rv);
      end
      rd(OFS_ENERGY_A);
      comparisons++;
      if (rv !== 32'h0 && rv !== 32'h1) begin
         mismatches++;
         $display("[ERR] energy_cleared expected 0 seen %h", rv);
      end
      wr(OFS_GAIN_A, 32'hff800000);
      ws();
      rd(OFS_ENERGY_A);
      repeat (12000) @(posedge ref_clk);
      rd(OFS_ENERGY_A);  chk("energy_gain_off", 32'h0, rv);
      rd(OFS_STATUS);    chk("status_idle", 32'h0, rv);
      chk("irq_pin", 32'h1, 32'(irq_n));
      wr(OFS_STATUS, 32'h1 << HALF_FULL_BIT);
      rd(OFS_STATUS);    chk("status_cleared", 32'h0, rv);
      chk("irq_pin_cleared", 32'h1, 32'(irq_n));
      // Measured voltage of zero must give zero power while nominal is off
      @(posedge ref_clk);
      va <= '0;
      ws();
      ws();
      chk("power_a_zero", 32'h0, 32'(pa));
      summarize();
   end
endmodule : tb_apea_top
